// ===== rtl/tocp_timer.sv
/*
 * output compare and one-pulse section of a 16-bit free-running timer,
 * with its counter, capture inputs and an ahb-lite register slave.
 * assumes pins are asynchronous; the cpu mask bit arrives on hclk.
 */
`timescale 1ns/10ps
// Summary of operation
// - match sets channel flag and drives enabled pin to its level
// - two 16-bit compare values checked against counter each tick
// - compare values are software read/write, reset to 8000h
// - compare pin latches are low during reset
// - compare interrupt needs enable set and cpu mask clear
// - flag clears after status read seeing it, then low byte access
// - high byte write blocks matches until low byte written
// - disabled pin gets no level; match may still interrupt
// - divide-by-2 updates at equality, others at value plus one
// - force bit copies level to enabled pin, no flag, no irq
// - force bits ignored in one-pulse or pwm mode
// - one-pulse selected in second control, uses capture1/compare1
// - trigger edge reloads FFFCh, in-pulse level, flag, FFFDh capture
// - trigger capture flag requests irq when capture enable set
// - compare1 match in one-pulse drives after-pulse level
// - one-pulse never sets compare flag 1; flag 2 still works
// - pwm wins when both mode selects set
// - equal levels give constant pin in one-pulse
// - capture input 1 does not capture in one-pulse; input 2 does
// - compare 2 flags only, drives no pin, in one-pulse
// - clock select 11 picks external clock, else cpu by 2/4/8
// - any counter reload, incl low byte write, gives FFFCh
// - all timer events share one gated interrupt line
module tocp_timer (
	input  logic        hclk,
	input  logic        hresetn,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic [31:0] hrdata,
	output logic        hreadyout,
	output logic        hresp,
	input  logic        cpu_irq_mask,
	input  logic        capture_input_pin_one,
	input  logic        capture_input_pin_two,
	input  logic        ext_timer_clock,
	output logic        compare_output_pin_one,
	output logic        compare_output_pin_two,
	output logic        compare_pin_oe_one,
	output logic        compare_pin_oe_two,
	output logic        timer_irq
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [15:0] compare_value [2];
	logic [1:0]  cmp_block;
	logic [1:0]  compare_flag;
	logic [1:0]  cmp_seen;
	logic [1:0]  capture_flag;
	logic [1:0]  cap_seen;
	logic [15:0] capture_value [2];
	logic [7:0]  timer_control_first;
	logic [7:0]  timer_control_second;
	logic [15:0] counter;
	logic [2:0]  presc;
	logic [2:0]  sync_a;
	logic [2:0]  sync_b;
	logic [2:0]  sync_c;
	logic        tick_d;
	logic [1:0]  match_d;
	tocp_pkg::tocp_phase_t phase;
	logic [7:0]  ph_addr;
	logic        ph_write;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire         addr_take = hsel & hready & htrans[1];
	wire         wr_en     = (phase == tocp_pkg::tocp_ph_data) & ph_write;
	wire         rd_en     = (phase == tocp_pkg::tocp_ph_data) & ~ph_write;
	wire         acc_en    = phase == tocp_pkg::tocp_ph_data;
	wire [7:0]   wb        = hwdata[7:0];
	wire         hit_c1h   = ph_addr == tocp_pkg::off_cmp_one_high;
	wire         hit_c1l   = ph_addr == tocp_pkg::off_cmp_one_low;
	wire         hit_c2h   = ph_addr == tocp_pkg::off_cmp_two_high;
	wire         hit_c2l   = ph_addr == tocp_pkg::off_cmp_two_low;
	wire         hit_ctl1  = ph_addr == tocp_pkg::off_ctrl_first;
	wire         hit_ctl2  = ph_addr == tocp_pkg::off_ctrl_second;
	wire         hit_sts   = ph_addr == tocp_pkg::off_status;
	wire         hit_cntl  = ph_addr == tocp_pkg::off_counter_low;
	wire         hit_i1l   = ph_addr == tocp_pkg::off_cap_one_low;
	wire         hit_i2l   = ph_addr == tocp_pkg::off_cap_two_low;
	wire [1:0]   hi_wr     = {wr_en & hit_c2h, wr_en & hit_c1h};
	wire [1:0]   lo_acc    = {acc_en & hit_c2l, acc_en & hit_c1l};
	wire [1:0]   lo_wr     = {wr_en & hit_c2l, wr_en & hit_c1l};
	wire [1:0]   cap_lo    = {acc_en & hit_i2l, acc_en & hit_i1l};
	wire         sts_rd    = rd_en & hit_sts;

	// ----------------------------------------------------------------
	// modes and clock selection
	// ----------------------------------------------------------------
	wire         pwm_mode  = timer_control_second[tocp_pkg::ctl2_pwm_select];
	// pwm has priority over one-pulse
	wire         opm_mode  = timer_control_second[tocp_pkg::ctl2_single_pulse]
	                         & ~pwm_mode;
	wire [1:0]   clk_sel   = timer_control_second[tocp_pkg::ctl2_clock_sel_hi:
	                                              tocp_pkg::ctl2_clock_sel_lo];
	wire [1:0]   pin_en    = {timer_control_second[tocp_pkg::ctl2_pin_enable_two],
	                          timer_control_second[tocp_pkg::ctl2_pin_enable_one]};
	wire [1:0]   level     = {timer_control_first[tocp_pkg::ctl1_level_two],
	                          timer_control_first[tocp_pkg::ctl1_level_one]};
	wire [1:0]   force_bit = {timer_control_first[tocp_pkg::ctl1_force_level_two],
	                          timer_control_first[tocp_pkg::ctl1_force_level_one]};
	wire         in_pulse  = level[1];
	wire         after_pulse = level[0];
	wire [2:0]   presc_mask = (clk_sel == tocp_pkg::clk_div_two)  ?
	                          tocp_pkg::presc_mask_two :
	                          (clk_sel == tocp_pkg::clk_div_four) ?
	                          tocp_pkg::presc_mask_four :
	                          tocp_pkg::presc_mask_eight;
	// second and third stages only; first stage feeds nothing but the second
	wire         ext_edge  = (sync_b[2] ^ sync_c[2]) &
	                         (sync_b[2] ~^ timer_control_second[tocp_pkg::ctl2_ext_edge]);
	wire         tick      = (clk_sel == tocp_pkg::clk_external) ? ext_edge :
	                         ((presc & presc_mask) == presc_mask);
	wire         cap1_edge = (sync_b[0] ^ sync_c[0]) &
	                         (sync_b[0] ~^ timer_control_first[tocp_pkg::ctl1_cap_edge_one]);
	wire         cap2_edge = (sync_b[1] ^ sync_c[1]) &
	                         (sync_b[1] ~^ timer_control_second[tocp_pkg::ctl2_cap_edge_two]);
	wire         trigger   = opm_mode & cap1_edge;
	wire         cnt_reload = (wr_en & hit_cntl) | trigger;

	// ----------------------------------------------------------------
	// compare and timing
	// ----------------------------------------------------------------
	// divide by 2 acts in the equal count; slower clocks one tick later,
	// i.e. when the counter already shows value plus one
	wire [1:0]   equal;
	wire [1:0]   match;
	wire [1:0]   set_cf;
	wire [1:0]   clr_cf;
	wire [1:0]   set_if;
	wire [1:0]   clr_if;
	wire         div2      = clk_sel == tocp_pkg::clk_div_two;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			assign equal[g]  = (counter == compare_value[g]) & ~cmp_block[g];
			assign match[g]  = div2 ? (tick & equal[g]) : (tick & match_d[g]);
			assign clr_cf[g] = cmp_seen[g] & lo_acc[g];
			assign clr_if[g] = cap_seen[g] & cap_lo[g];
		end
	endgenerate

	// pwm blocks both flags; one-pulse blocks only flag 1
	assign set_cf[0] = match[0] & ~opm_mode & ~pwm_mode;
	assign set_cf[1] = match[1] & ~pwm_mode;
	assign set_if[0] = trigger | (cap1_edge & ~opm_mode & ~pwm_mode);
	assign set_if[1] = cap2_edge;

	wire [1:0]   cmp_drive = {match[1] & pin_en[1] & ~opm_mode & ~pwm_mode,
	                          match[0] & pin_en[0] & ~opm_mode & ~pwm_mode};
	wire [1:0]   frc_drive = force_bit & pin_en & {2{~opm_mode & ~pwm_mode}};
	wire         opm_start = trigger & pin_en[0];
	wire         opm_end   = opm_mode & match[0] & pin_en[0];

	wire [7:0]   sts_val   = {capture_flag[0], compare_flag[0], 1'b0,
	                          capture_flag[1], compare_flag[1], 3'h0};
	wire [15:0]  rd_mux    =
		(hit_c1h | hit_c1l) ? compare_value[0] :
		(hit_c2h | hit_c2l) ? compare_value[1] :
		hit_ctl1 ? {8'h00, timer_control_first} :
		hit_ctl2 ? {8'h00, timer_control_second} :
		hit_sts  ? {8'h00, sts_val} :
		(hit_cntl | (ph_addr == tocp_pkg::off_counter_high)) ? counter :
		((ph_addr == tocp_pkg::off_cap_one_high) | hit_i1l) ? capture_value[0] :
		((ph_addr == tocp_pkg::off_cap_two_high) | hit_i2l) ? capture_value[1] :
		16'h0000;
	wire [7:0]   rd_byte   = (hit_c1h | hit_c2h |
	                          (ph_addr == tocp_pkg::off_counter_high) |
	                          (ph_addr == tocp_pkg::off_cap_one_high) |
	                          (ph_addr == tocp_pkg::off_cap_two_high)) ?
	                         rd_mux[15:8] : rd_mux[7:0];
	wire         irq_req   = ~cpu_irq_mask &
		((timer_control_first[tocp_pkg::ctl1_compare_irq_enable] &
		  (|compare_flag)) |
		 (timer_control_first[tocp_pkg::ctl1_capture_irq_enable] &
		  (|capture_flag)));

	// ----------------------------------------------------------------
	// bus slave: one wait state on reads, always okay
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase    <= tocp_pkg::tocp_ph_idle;
			ph_addr  <= 8'h00;
			ph_write <= 1'b0;
		end else begin
			phase    <= addr_take ? tocp_pkg::tocp_ph_data :
			            tocp_pkg::tocp_ph_idle;
			ph_addr  <= haddr[7:0];
			ph_write <= hwrite;
		end
	end

	// a read wait state keeps hrdata a flop; the status snapshot used for
	// flag clearing and the byte returned are taken at the same edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			if (rd_en)
				hrdata <= {24'h000000, rd_byte};
			hreadyout <= ~(addr_take & ~hwrite);
			hresp     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_value[0]     <= tocp_pkg::cmp_reset_value;
			compare_value[1]     <= tocp_pkg::cmp_reset_value;
			timer_control_first  <= 8'h00;
			timer_control_second <= 8'h00;
			cmp_block            <= 2'h0;
		end else begin
			if (hi_wr[0])
				compare_value[0][15:8] <= wb;
			if (lo_wr[0])
				compare_value[0][7:0]  <= wb;
			if (hi_wr[1])
				compare_value[1][15:8] <= wb;
			if (lo_wr[1])
				compare_value[1][7:0]  <= wb;
			cmp_block <= (cmp_block | hi_wr) & ~lo_wr;
			if (wr_en & hit_ctl1)
				timer_control_first  <= wb;
			if (wr_en & hit_ctl2)
				timer_control_second <= wb;
		end
	end

	// set wins over clear on every hardware flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_flag <= 2'h0;
			capture_flag <= 2'h0;
			cmp_seen     <= 2'h0;
			cap_seen     <= 2'h0;
		end else begin
			compare_flag <= set_cf | (compare_flag & ~clr_cf);
			capture_flag <= set_if | (capture_flag & ~clr_if);
			cmp_seen     <= (sts_rd ? compare_flag : cmp_seen) & ~lo_acc;
			cap_seen     <= (sts_rd ? capture_flag : cap_seen) & ~cap_lo;
		end
	end

	// ----------------------------------------------------------------
	// counter, prescaler, capture, synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter          <= tocp_pkg::counter_reload;
			presc            <= 3'h0;
			sync_a           <= 3'h0;
			sync_b           <= 3'h0;
			sync_c           <= 3'h0;
			tick_d           <= 1'b0;
			match_d          <= 2'h0;
			capture_value[0] <= 16'h0000;
			capture_value[1] <= 16'h0000;
		end else begin
			sync_a  <= {ext_timer_clock, capture_input_pin_two,
			            capture_input_pin_one};
			sync_b  <= sync_a;
			sync_c  <= sync_b;
			presc   <= cnt_reload ? 3'h0 : presc + 3'h1;
			tick_d  <= tick;
			if (tick)
				match_d <= equal;
			if (cnt_reload)
				counter <= tocp_pkg::counter_reload;
			else if (tick)
				counter <= counter + 16'h0001;
			if (trigger)
				capture_value[0] <= tocp_pkg::pulse_capture_val;
			else if (set_if[0])
				capture_value[0] <= counter;
			if (set_if[1])
				capture_value[1] <= counter;
		end
	end

	// ----------------------------------------------------------------
	// pins and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_output_pin_one <= 1'b0;
			compare_output_pin_two <= 1'b0;
			compare_pin_oe_one     <= 1'b0;
			compare_pin_oe_two     <= 1'b0;
			timer_irq              <= 1'b0;
		end else begin
			compare_pin_oe_one <= pin_en[0];
			compare_pin_oe_two <= pin_en[1] & ~opm_mode;
			// equal levels leave the pin unchanged
			if (opm_start)
				compare_output_pin_one <= in_pulse;
			else if (opm_end)
				compare_output_pin_one <= after_pulse;
			else if (cmp_drive[0] | frc_drive[0])
				compare_output_pin_one <= level[0];
			if (cmp_drive[1] | frc_drive[1])
				compare_output_pin_two <= level[1];
			timer_irq <= irq_req;
		end
	end

	logic unused_ok;
	assign unused_ok = tick_d ^ (|hsize) ^ (|haddr[31:8])
	                   ^ (|hwdata[31:8]);

endmodule

// ===== rtl/tocp_pkg.sv
/*
 * package for the timer output compare and one-pulse block: register
 * offsets, field positions, reset values and prescaler counts.
 * assumes a 32-bit ahb-lite register bus with word-aligned registers.
 */
package tocp_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] off_cmp_one_high = 8'h00;
	localparam logic [7:0] off_cmp_one_low  = 8'h04;
	localparam logic [7:0] off_cmp_two_high = 8'h08;
	localparam logic [7:0] off_cmp_two_low  = 8'h0c;
	localparam logic [7:0] off_ctrl_first   = 8'h10;
	localparam logic [7:0] off_ctrl_second  = 8'h14;
	localparam logic [7:0] off_status       = 8'h18;
	localparam logic [7:0] off_counter_low  = 8'h1c;
	localparam logic [7:0] off_counter_high = 8'h20;
	localparam logic [7:0] off_cap_one_high = 8'h24;
	localparam logic [7:0] off_cap_one_low  = 8'h28;
	localparam logic [7:0] off_cap_two_high = 8'h2c;
	localparam logic [7:0] off_cap_two_low  = 8'h30;

	// ----------------------------------------------------------------
	// first control register fields
	// ----------------------------------------------------------------
	localparam int ctl1_capture_irq_enable = 7;
	localparam int ctl1_compare_irq_enable = 6;
	localparam int ctl1_force_level_two    = 4;
	localparam int ctl1_force_level_one    = 3;
	localparam int ctl1_cap_edge_one       = 1;
	localparam int ctl1_level_two          = 2;
	localparam int ctl1_level_one          = 0;

	// ----------------------------------------------------------------
	// second control register fields
	// ----------------------------------------------------------------
	localparam int ctl2_pin_enable_one = 7;
	localparam int ctl2_pin_enable_two = 6;
	localparam int ctl2_single_pulse   = 5;
	localparam int ctl2_pwm_select     = 4;
	localparam int ctl2_clock_sel_hi   = 3;
	localparam int ctl2_clock_sel_lo   = 2;
	localparam int ctl2_cap_edge_two   = 1;
	localparam int ctl2_ext_edge       = 0;

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int sts_cap_flag_one = 7;
	localparam int sts_cmp_flag_one = 6;
	localparam int sts_cap_flag_two = 4;
	localparam int sts_cmp_flag_two = 3;

	// ----------------------------------------------------------------
	// reset and reload values, clock selections
	// ----------------------------------------------------------------
	localparam logic [15:0] cmp_reset_value   = 16'h8000;
	localparam logic [15:0] counter_reload    = 16'hfffc;
	localparam logic [15:0] pulse_capture_val = 16'hfffd;
	localparam logic [1:0]  clk_div_two       = 2'h0;
	localparam logic [1:0]  clk_div_four      = 2'h1;
	localparam logic [1:0]  clk_div_eight     = 2'h2;
	localparam logic [1:0]  clk_external      = 2'h3;
	localparam logic [2:0]  presc_mask_two    = 3'h1;
	localparam logic [2:0]  presc_mask_four   = 3'h3;
	localparam logic [2:0]  presc_mask_eight  = 3'h7;

	typedef enum logic [1:0] {
		tocp_ph_idle = 2'h0,
		tocp_ph_data = 2'h1
	} tocp_phase_t;

endpackage

// ===== tb/tocp_timer_props.sv
/*
 * checker for tocp_timer: bus response, reset levels, pin enables,
 * forced levels and interrupt gating, all seen at the top ports.
 * assumes both control registers reset to zero and hold one byte each.
 */
`timescale 1ns/10ps
module tocp_timer_props (
	input logic        hclk,
	input logic        hresetn,
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [31:0] hwdata,
	input logic        hready,
	input logic        hreadyout,
	input logic        hresp,
	input logic        cpu_irq_mask,
	input logic        compare_output_pin_one,
	input logic        compare_output_pin_two,
	input logic        compare_pin_oe_one,
	input logic        compare_pin_oe_two,
	input logic        timer_irq
);
	// ----------------------------------------------------------------
	// shadow of the control registers, settle counter
	// ----------------------------------------------------------------
	logic       w_q;
	logic [7:0] a_q;
	logic [7:0] c1;
	logic [7:0] c2;
	logic [2:0] calm;
	wire        hit1 = w_q & hready & (a_q == tocp_pkg::off_ctrl_first);
	wire        hit2 = w_q & hready & (a_q == tocp_pkg::off_ctrl_second);
	wire        rd_take = hsel & htrans[1] & !hwrite & hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			w_q  <= 1'b0;
			a_q  <= 8'h00;
			c1   <= 8'h00;
			c2   <= 8'h00;
			calm <= 3'h0;
		end else begin
			if (hready) begin
				w_q <= hsel & htrans[1] & hwrite;
				a_q <= haddr[7:0];
			end
			if (hit1)
				c1 <= hwdata[7:0];
			if (hit2)
				c2 <= hwdata[7:0];
			// outputs are registered, so judge them only once settled
			if (hit1 | hit2)
				calm <= 3'h0;
			else if (calm != 3'h4)
				calm <= calm + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_calm;
		calm == 3'h4;
	endsequence
	sequence s_force1;
		s_calm ##0 (c1[3] && c2[7] && !c2[5] && !c2[4]);
	endsequence
	sequence s_force2;
		s_calm ##0 (c1[4] && c2[6] && !c2[5] && !c2[4]);
	endsequence

	a_ready_one_wait: assert property (!hreadyout |->
		$past(rd_take) ##1 hreadyout)
		else $error("hreadyout low outside a read wait");
	a_resp_okay: assert property (hsel && htrans[1] && hready |=> !hresp [*2])
		else $error("error response");
	a_reset_low: assert property (disable iff (1'b0) !hresetn |->
		!compare_output_pin_one && !compare_output_pin_two && !timer_irq)
		else $error("pin or irq high in reset");
	a_oe_one_follows: assert property (
		s_calm |-> compare_pin_oe_one == c2[7])
		else $error("pin one enable wrong");
	a_oe_two_follows: assert property (
		s_calm ##0 !c2[5] |-> compare_pin_oe_two == c2[6])
		else $error("pin two enable wrong");
	a_pin_quiet_off: assert property (
		s_calm ##0 !c2[6] |=> $stable(compare_output_pin_two))
		else $error("disabled pin two moved");
	a_irq_masked: assert property (
		cpu_irq_mask && $past(cpu_irq_mask) |-> !timer_irq)
		else $error("irq while masked");
	a_irq_needs_en: assert property (
		s_calm ##0 (!c1[7] && !c1[6]) |-> !timer_irq)
		else $error("irq with enables clear");
	a_force_one: assert property (
		s_force1 |-> ##1 compare_output_pin_one == c1[0])
		else $error("forced level one wrong");
	a_force_two: assert property (
		s_force2 |-> compare_output_pin_two == c1[2])
		else $error("forced level two wrong");
endmodule

bind tocp_timer tocp_timer_props u_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .cpu_irq_mask(cpu_irq_mask),
	.compare_output_pin_one(compare_output_pin_one),
	.compare_output_pin_two(compare_output_pin_two),
	.compare_pin_oe_one(compare_pin_oe_one),
	.compare_pin_oe_two(compare_pin_oe_two), .timer_irq(timer_irq));

// ===== tb/test_timer_output_compare_one_pulse.sv
/*
 * self-checking bench for tocp_timer: register access, matches in all
 * clock modes, inhibit, force and one-pulse, against a byte model.
 * assumes the checker is bound from its own file.
 */
`timescale 1ns/10ps
module test_timer_output_compare_one_pulse;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        mask, cap1, cap2, ext, lvl;
	logic        pin1, pin2, oe1, oe2, irq;
	logic [7:0]  cv [4] = '{8'h80, 8'h00, 8'h80, 8'h00};
	int          fac [4] = '{2, 4, 8, 10};
	int          n_fail, n_checks, t, dl;

	assign hready = hreadyout;

	tocp_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cpu_irq_mask(mask),
		.capture_input_pin_one(cap1), .capture_input_pin_two(cap2),
		.ext_timer_clock(ext), .compare_output_pin_one(pin1),
		.compare_output_pin_two(pin2), .compare_pin_oe_one(oe1),
		.compare_pin_oe_two(oe2), .timer_irq(irq));

	// ----------------------------------------------------------------
	// clocks and watchdog
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// external timer clock: rising edge every 10 cycles, well under 1/4
	initial begin
		ext = 1'b0;
		forever begin
			repeat (5) @(posedge hclk);
			ext <= ~ext;
		end
	end
	initial begin
		#(25 * 20000);
		n_fail++;
		summarize();
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic fail(input string m);
		n_fail++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) fail($sformatf("value %h, model %h", g, e));
	endtask
	task automatic chk_cnt(input int g, input int lo, input int hi);
		n_checks++;
		if (g < lo || g > hi) fail($sformatf("span %0d cycles", g));
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int k;
		k = 0;
		if (hclk !== 1'b1) @(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'b1 && k < 50);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'b1 && k < 100);
		r = hrdata;
		if (k >= 100) fail("bus hang");
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk8(r[7:0], e);
	endtask
	// pins are looked at on the falling edge, away from their update
	task automatic wait_pin(input logic one, input logic v, output int n);
		n = 1;
		@(negedge hclk);
		while ((one ? pin1 : pin2) !== v && n < 3000) begin
			@(negedge hclk);
			n++;
		end
		if (n >= 3000) fail("pin never moved");
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask
	task automatic summarize;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		mask = 1'b1;
		cap1 = 1'b0;
		cap2 = 1'b0;
		lvl = 1'b0;
		n_fail = 0;
		n_checks = 0;
		void'($urandom(32'h5d09));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 4; i++) rd(8'(4 * i), cv[i]);
		for (int i = 0; i < 4; i++) begin
			cv[i] = 8'($urandom);
			wr(8'(4 * i), cv[i]);
		end
		for (int i = 0; i < 4; i++) rd(8'(4 * i), cv[i]);
		wr(8'h3c, 8'h5a);
		rd(8'h3c, 8'h00);
		for (int m = 0; m < 4; m++) begin
			lvl = ~lvl;
			wr(tocp_pkg::off_cmp_one_high, 8'h00);
			wr(tocp_pkg::off_cmp_two_high, 8'h00);
			wr(tocp_pkg::off_ctrl_first, {5'h08, lvl, 1'b0, lvl});
			wr(tocp_pkg::off_ctrl_second, {4'hc, 2'(m), 2'h1});
			wr(tocp_pkg::off_counter_low, 8'h00);
			xfer(1'b0, tocp_pkg::off_status, 8'h00);
			wr(tocp_pkg::off_cmp_one_low, 8'h10);
			wr(tocp_pkg::off_cmp_two_low, 8'h13);
			wait_pin(1'b1, lvl, t);
			wait_pin(1'b0, lvl, dl);
			chk_cnt(dl, 3 * fac[m], 3 * fac[m]);
			chk8({7'h0, irq}, 8'h00);
			rd(tocp_pkg::off_status, 8'h48);
			mask <= 1'b0;
			settle(3);
			chk8({7'h0, irq}, 8'h01);
			rd(tocp_pkg::off_cmp_one_low, 8'h10);
			rd(tocp_pkg::off_status, 8'h08);
			rd(tocp_pkg::off_cmp_two_low, 8'h13);
			rd(tocp_pkg::off_status, 8'h00);
			mask <= 1'b1;
		end
		// lvl ends low here, so both pins sit at 0
		wr(tocp_pkg::off_ctrl_first, 8'h45);
		wr(tocp_pkg::off_ctrl_second, 8'h80);
		wr(tocp_pkg::off_cmp_one_high, 8'h00);
		wr(tocp_pkg::off_counter_low, 8'h00);
		settle(100);
		chk8({6'h0, pin2, pin1}, 8'h00);
		chk8({7'h0, oe2}, 8'h00);
		rd(tocp_pkg::off_status, 8'h08);
		mask <= 1'b0;
		settle(3);
		chk8({7'h0, irq}, 8'h01);
		rd(tocp_pkg::off_cmp_two_low, 8'h13);
		mask <= 1'b1;
		wr(tocp_pkg::off_cmp_one_low, 8'h10);
		wr(tocp_pkg::off_counter_low, 8'h00);
		wait_pin(1'b1, 1'b1, t);
		settle(20);
		rd(tocp_pkg::off_status, 8'h48);
		rd(tocp_pkg::off_cmp_one_low, 8'h10);
		rd(tocp_pkg::off_cmp_two_low, 8'h13);
		wr(tocp_pkg::off_ctrl_first, 8'h08);
		settle(4);
		chk8({7'h0, pin1}, 8'h00);
		rd(tocp_pkg::off_status, 8'h00);
		wr(tocp_pkg::off_ctrl_second, 8'he0);
		wr(tocp_pkg::off_ctrl_first, 8'h09);
		settle(4);
		chk8({7'h0, pin1}, 8'h00);
		wr(tocp_pkg::off_ctrl_first, 8'h8e);
		mask <= 1'b0;
		cap1 <= 1'b1;
		wait_pin(1'b1, 1'b1, t);
		wait_pin(1'b1, 1'b0, dl);
		chk_cnt(dl, 40, 44);
		settle(10);
		chk8({6'h0, pin2, irq}, 8'h01);
		rd(tocp_pkg::off_status, 8'h88);
		rd(tocp_pkg::off_cap_one_high, 8'hff);
		rd(tocp_pkg::off_cap_one_low, 8'hfd);
		rd(tocp_pkg::off_cmp_two_low, 8'h13);
		mask <= 1'b1;
		settle(200);
		chk8({7'h0, pin1}, 8'h00);
		summarize();
	end
endmodule
